/* e1pm_map.vh */
// Register map and constants of the receive error counter block.
// Assumes byte-wide register port with 16-bit addresses.
`ifndef E1PM_MAP_VH
`define E1PM_MAP_VH

`define E1PM_ADDR_W 16
// Upper byte of line violation tally; offset not printed, placed below low
`define E1PM_LCV_HIGH 16'h0900
`define E1PM_LCV_LOW 16'h0901
`define E1PM_FAE_HIGH 16'h0902
`define E1PM_FAE_LOW 16'h0903
`define E1PM_SEF 16'h0904
`define E1PM_CRC_HIGH 16'h0905
`define E1PM_CRC_LOW 16'h0906
`define E1PM_INT_STAT 16'h0910
`define E1PM_INT_MASK 16'h0911
// Interrupt status bit positions
`define E1PM_IRQ_LCV 0
`define E1PM_IRQ_FAE 1
`define E1PM_IRQ_SEF 2
`define E1PM_IRQ_CRC 3
`define E1PM_IRQ_W 4
`define E1PM_CNT_RST 16'h0000
`define E1PM_BYTE_RST 8'h00
`define E1PM_MASK_RST 4'h0

`endif

/* e1pm_counter.v */
// One clear-on-read error counter with low-byte snapshot.
// Assumes event and read pulses are synchronous to clk.
`timescale 1ns/1ps
`include "e1pm_map.vh"

module e1pm_counter (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Event and host reads
	input wire event_in,
	input wire rd_high,
	input wire rd_low,
	// Values seen by the host
	output wire [15:0] live,
	output wire [7:0] held_low
);
	reg [15:0] cnt_ff;
	reg [7:0] low_ff;
	reg [15:0] nxt_cnt;

	always @* begin
		nxt_cnt = cnt_ff;
		if (rd_high) begin
			// clear on read, keep concurrent event
			nxt_cnt = {15'h0000, event_in};
		end else if (event_in && cnt_ff != 16'hffff) begin
			// Saturate rather than wrap so overflow never reads small
			nxt_cnt = cnt_ff + 16'h0001;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= `E1PM_CNT_RST;
			low_ff <= `E1PM_BYTE_RST;
		end else begin
			cnt_ff <= nxt_cnt;
			// snapshot low byte; the live count keeps events that
			// arrive between the two byte reads for the next pair
			if (rd_high)
				low_ff <= cnt_ff[7:0];
			else if (rd_low)
				low_ff <= `E1PM_BYTE_RST;
		end
	end

	assign live = cnt_ff;
	assign held_low = low_ff;
endmodule // e1pm_counter

/* e1pm_top.v */
// Receive error performance counters of an E1 framer.
// Assumes framer event pulses on clk, one per event, and a byte register
// port with read data one cycle after the read strobe.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`include "e1pm_map.vh"

module e1pm_top (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Framer event pulses
	input wire line_violation,
	input wire frame_align_error,
	input wire frame_align_ok,
	input wire loss_of_frame,
	input wire crc_sync_error,
	// Register port
	input wire [15:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	output wire [7:0] rdata,
	// Interrupt
	output wire irq
);
	reg [7:0] rdata_ff;
	reg [7:0] sef_ff;
	reg [7:0] nxt_sef;
	reg [2:0] sef_state_ff;
	reg [2:0] nxt_sef_state;
	reg sef_ev;
	reg [`E1PM_IRQ_W-1:0] stat_ff;
	reg [`E1PM_IRQ_W-1:0] nxt_stat;
	reg [`E1PM_IRQ_W-1:0] mask_ff;
	reg [`E1PM_IRQ_W-1:0] nxt_mask;
	reg [7:0] nxt_rdata;
	wire [15:0] lcv_live;
	wire [15:0] fae_live;
	wire [15:0] crc_live;
	wire [7:0] lcv_low;
	wire [7:0] fae_low;
	wire [7:0] crc_low;
	wire [`E1PM_IRQ_W-1:0] ev_vec;
	wire rd_lcv_h;
	wire rd_lcv_l;
	wire rd_fae_h;
	wire rd_fae_l;
	wire rd_crc_h;
	wire rd_crc_l;
	wire rd_sef;
	wire wr_stat;
	wire wr_mask;

	// Severe frame detector states, one-hot
	localparam [2:0] SEF_CLEAN = 3'h1;
	localparam [2:0] SEF_ONE_ERR = 3'h2;
	localparam [2:0] SEF_ARMED = 3'h4;

	assign rd_lcv_h = rd && addr == `E1PM_LCV_HIGH;
	assign rd_lcv_l = rd && addr == `E1PM_LCV_LOW;
	assign rd_fae_h = rd && addr == `E1PM_FAE_HIGH;
	assign rd_fae_l = rd && addr == `E1PM_FAE_LOW;
	assign rd_crc_h = rd && addr == `E1PM_CRC_HIGH;
	assign rd_crc_l = rd && addr == `E1PM_CRC_LOW;
	assign rd_sef = rd && addr == `E1PM_SEF;
	assign wr_stat = wr && addr == `E1PM_INT_STAT;
	assign wr_mask = wr && addr == `E1PM_INT_MASK;

	e1pm_counter u_lcv (
		.clk(clk),
		.rst(rst),
		.event_in(line_violation),
		.rd_high(rd_lcv_h),
		.rd_low(rd_lcv_l),
		.live(lcv_live),
		.held_low(lcv_low)
	);

	e1pm_counter u_fae (
		.clk(clk),
		.rst(rst),
		.event_in(frame_align_error),
		.rd_high(rd_fae_h),
		.rd_low(rd_fae_l),
		.live(fae_live),
		.held_low(fae_low)
	);

	e1pm_counter u_crc (
		.clk(clk),
		.rst(rst),
		.event_in(crc_sync_error),
		.rd_high(rd_crc_h),
		.rd_low(rd_crc_l),
		.live(crc_live),
		.held_low(crc_low)
	);

	// A pair of errored FAS words arms the detector; the pair is counted at
	// the next FAS word only if the framer has not declared loss of frame,
	// since a pair that causes the loss is not a severely errored frame.
	always @* begin
		nxt_sef_state = sef_state_ff;
		sef_ev = 1'b0;
		case (sef_state_ff)
			SEF_CLEAN: begin
				if (!loss_of_frame && frame_align_error)
					nxt_sef_state = SEF_ONE_ERR;
			end
			SEF_ONE_ERR: begin
				if (loss_of_frame)
					nxt_sef_state = SEF_CLEAN;
				else if (frame_align_error)
					nxt_sef_state = SEF_ARMED;
				else if (frame_align_ok)
					nxt_sef_state = SEF_CLEAN;
			end
			SEF_ARMED: begin
				if (!loss_of_frame &&
				    (frame_align_ok || frame_align_error))
					sef_ev = 1'b1;
				// A third error starts a new pair
				if (loss_of_frame)
					nxt_sef_state = SEF_CLEAN;
				else if (frame_align_error)
					nxt_sef_state = SEF_ONE_ERR;
				else if (frame_align_ok)
					nxt_sef_state = SEF_CLEAN;
			end
			default: begin
				// An illegal code falls back to a clean detector
				nxt_sef_state = SEF_CLEAN;
			end
		endcase
	end

	always @* begin
		nxt_sef = sef_ff;
		if (rd_sef)
			nxt_sef = {7'h00, sef_ev};
		else if (sef_ev && sef_ff != 8'hff)
			nxt_sef = sef_ff + 8'h01;
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sef_state_ff <= SEF_CLEAN;
			sef_ff <= `E1PM_BYTE_RST;
		end else begin
			sef_state_ff <= nxt_sef_state;
			sef_ff <= nxt_sef;
		end
	end

	assign ev_vec = {crc_sync_error, sef_ev, frame_align_error,
		line_violation};

	// Set beats write-one-to-clear in the same cycle, so no event is lost
	always @* begin
		nxt_stat = stat_ff | ev_vec;
		nxt_mask = mask_ff;
		if (wr_stat)
			nxt_stat = (stat_ff & ~wdata[`E1PM_IRQ_W-1:0]) | ev_vec;
		if (wr_mask)
			nxt_mask = wdata[`E1PM_IRQ_W-1:0];
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			stat_ff <= {`E1PM_IRQ_W{1'b0}};
			mask_ff <= `E1PM_MASK_RST;
		end else begin
			stat_ff <= nxt_stat;
			mask_ff <= nxt_mask;
		end
	end

	assign irq = |(stat_ff & mask_ff);

	always @* begin
		nxt_rdata = 8'h00;
		if (rd) begin
			case (addr)
				`E1PM_LCV_HIGH: nxt_rdata = lcv_live[15:8];
				`E1PM_FAE_HIGH: nxt_rdata = fae_live[15:8];
				`E1PM_CRC_HIGH: nxt_rdata = crc_live[15:8];
				`E1PM_LCV_LOW: nxt_rdata = lcv_low;
				`E1PM_FAE_LOW: nxt_rdata = fae_low;
				`E1PM_CRC_LOW: nxt_rdata = crc_low;
				`E1PM_SEF: nxt_rdata = sef_ff;
				`E1PM_INT_STAT: nxt_rdata = {4'h0, stat_ff};
				`E1PM_INT_MASK: nxt_rdata = {4'h0, mask_ff};
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst)
			rdata_ff <= `E1PM_BYTE_RST;
		else
			rdata_ff <= nxt_rdata;
	end

	assign rdata = rdata_ff;
endmodule // e1pm_top

/* e1pm_checker.sv */
// Assertions on the receive error counters, bound to e1pm_top.
// Assumes one-cycle host strobes and the fixed register offsets.
`timescale 1ns/1ps
module e1pm_checker (
	// Clock, reset, events
	input clk, rst, line_violation, frame_align_error, frame_align_ok,
	input loss_of_frame, crc_sync_error,
	// Register port
	input wr, rd, irq,
	input [15:0] addr,
	input [7:0] wdata, rdata
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire fe = frame_align_error;
	wire fo = frame_align_ok;
	wire lv = line_violation;
	wire ce = crc_sync_error;
	wire q = !rd && !fo && !loss_of_frame;
	wire z = q && !fe;
	wire g = !rd && !fe && !loss_of_frame;
	wire s4 = rd && addr == 16'h0904 && !fe && !fo;
	wire h0 = rd && addr == 16'h0900;
	wire h2 = rd && addr == 16'h0902;
	wire h5 = rd && addr == 16'h0905;
	// Good FAS empties the detector, a read clears the tally, then a pair
	sequence pre;
		fo && g ##1 z ##1 s4 ##1 z ##1 (fe && q) [*2] ##1 z;
	endsequence
	a_lcv_clear: assert property (h0 && !lv ##1 !(rd || lv) ##1 h0
		|=> rdata == 8'h00) else $error("lcv kept");
	a_fae_clear: assert property (h2 && !fe ##1 !(rd || fe) ##1 h2
		|=> rdata == 8'h00) else $error("fae kept");
	a_crc_clear: assert property (h5 && !ce ##1 !(rd || ce) ##1 h5
		|=> rdata == 8'h00) else $error("crc kept");
	a_sef_clear: assert property (s4 ##1 z ##1 s4
		|=> rdata == 8'h00) else $error("sef kept");
	a_sef_pair: assert property (pre ##1 fo && g ##1 z ##1 s4
		|=> rdata == 8'h01) else $error("pair lost");
	a_sef_lof: assert property (pre ##1 fo && !rd && loss_of_frame
		##1 z ##1 s4 |=> rdata == 8'h00) else $error("lof counted");
	a_unmapped_zero: assert property (rd && addr == 16'h0907
		|=> rdata == 8'h00) else $error("unmapped data");
	a_idle_zero: assert property (!rd |=> rdata == 8'h00)
		else $error("data off read");
	cover property (h0 ##2 rd && addr == 16'h0901);
	cover property (pre ##1 fo);
	cover property (irq);
endmodule // e1pm_checker

bind e1pm_top e1pm_checker chk (.clk, .rst, .line_violation,
	.frame_align_error, .frame_align_ok, .loss_of_frame, .crc_sync_error,
	.addr, .wdata, .wr, .rd, .rdata, .irq);

/* e1pm_top_tb.sv */
// Bench of the receive error counters: count table, then hand tests.
// Assumes the register offsets of e1pm_top.
`timescale 1ns/1ps
module e1pm_top_tb;
	reg clk = 0, rst = 1, wr = 0, rd = 0;
	reg [4:0] ev = 0, b;
	reg [15:0] addr = 0, a, n, e;
	reg [7:0] wdata = 0;
	reg [52:0] rows [0:2];
	wire [7:0] rdata;
	wire irq;
	integer failures = 0, total_checks = 0, i;
	e1pm_top uut (.clk, .rst, .line_violation(ev[4]),
		.frame_align_error(ev[3]), .frame_align_ok(ev[2]),
		.loss_of_frame(ev[1]), .crc_sync_error(ev[0]), .addr, .wdata,
		.wr, .rd, .rdata, .irq);
	task cmp(input string s, input [7:0] x, g);
		total_checks++;
		if (g !== x) begin
			failures++;
			$display("BAD %s exp %h got %h", s, x, g);
		end
	endtask
	task rdc(input [15:0] ad, input [7:0] x);
		@(posedge clk) addr <= ad;
		rd <= 1;
		@(posedge clk) rd <= 0;
		#1 cmp("rdata", x, rdata);
	endtask
	task wrt(input [15:0] ad, input [7:0] d);
		@(posedge clk) addr <= ad;
		wdata <= d;
		wr <= 1;
		@(posedge clk) wr <= 0;
		#1;
	endtask
	task pulse(input [4:0] v, input [15:0] k);
		repeat (k) @(posedge clk) ev <= v;
		@(posedge clk) ev <= 0;
		#1;
	endtask
	task final_report;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial forever #2 clk = ~clk;
	// Whole run is near 2500 ns
	initial begin
		#100000;
		failures++;
		final_report;
	end
	initial begin
		rows[0] = {16'h0900, 5'h10, 16'd3, 16'h0003};
		rows[1] = {16'h0902, 5'h08, 16'd257, 16'h0101};
		rows[2] = {16'h0905, 5'h01, 16'd256, 16'h0100};
		repeat (12) @(posedge clk);
		rst <= 0;
		for (i = 0; i < 3; i++) begin
			{a, b, n, e} = rows[i];
			pulse(b, n);
			rdc(a, e[15:8]);
			rdc(a + 16'h0001, e[7:0]);
			repeat (2) rdc(a, 8'h00);
			$display("row %0d end", i);
		end
		pulse(5'h11, 2);
		rst <= 1;
		@(posedge clk) rst <= 0;
		// Every counter register and the unmapped 0x0907 read zero after a mid-run reset
		for (i = 0; i < 8; i++)
			rdc(16'h0900 + 16'((i + 5) % 8), 8'h00);
		$display("reset end");
		// A good FAS first, so the detector starts empty
		pulse(5'h04, 1);
		rdc(16'h0904, 8'h00);
		pulse(5'h08, 2);
		pulse(5'h04, 1);
		rdc(16'h0904, 8'h01);
		pulse(5'h08, 2);
		pulse(5'h06, 1);
		repeat (2) rdc(16'h0904, 8'h00);
		$display("severe frame end");
		wrt(16'h0911, 8'h01);
		pulse(5'h10, 1);
		cmp("irq", 8'h01, {7'h00, irq});
		wrt(16'h0911, 8'h00);
		cmp("irq", 8'h00, {7'h00, irq});
		wrt(16'h0910, 8'h0f);
		wrt(16'h0911, 8'h0f);
		cmp("irq", 8'h00, {7'h00, irq});
		$display("irq end");
		// Events between the two byte reads wait for the next pair
		rdc(16'h0900, 8'h00);
		pulse(5'h10, 1);
		rdc(16'h0901, 8'h01);
		rdc(16'h0900, 8'h00);
		rdc(16'h0901, 8'h01);
		$display("split read end");
		final_report;
	end
endmodule // e1pm_top_tb
